//--- src/flow_through_sync_burst_sram.sv
// flow-through synchronous burst memory with back-to-back read and write
// assumes a synchronous controller; the data bus is resolved outside
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_consts.svh"

// Behaviour
// RULE1: all control, address and lane inputs are registered on the rising edge; sleep_request, outputEnableN and clock_qualifier_n are used unregistered
// RULE2: a high clock qualifier freezes every register and the output data
// RULE3: reads and writes mix freely on consecutive edges with no dead cycle
// RULE4: store words of four 9-bit lanes, each lane with its parity bit
// RULE5: write strobe low writes; only lanes with a low lane select change
// RULE6: write completes internally at the edge ending its data phase
// RULE7: selected only when all three chip selects are at active levels
// RULE8: output enable gates the data drivers with no clock involved
// RULE9: drivers released during every write data phase without help
// RULE10: read data follows in the cycle starting at the address edge
// RULE11: burst order linear or interleaved per a static select input
// RULE12: sleep request or deselect puts the memory in low power
// RULE13: advance_or_load low loads an address, high steps a 4-beat burst
// RULE14: controller drives write data only in write data phases
module flow_through_sync_burst_sram
  import burst_sram_pkg::*;
#(
  parameter int ADDR_W = `SRAM_ADDR_W,
  parameter int DEPTH  = `SRAM_DEPTH,
  parameter int LANES  = `SRAM_LANES
) (
  // clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  // address; the two lowest bits seed the burst counter
  input  wire logic [ADDR_W-1:2]     addrUpper,
  input  wire logic                  burst_addr_bit0,
  input  wire logic                  burst_addr_bit1,
  // chip selects
  input  wire logic                  chip_select_a_n,
  input  wire logic                  chip_select_b,
  input  wire logic                  chip_select_c_n,
  // operation control
  input  wire logic                  writeStrobeN,
  input  wire logic [LANES-1:0]      byte_lane_write_sel_n,
  input  wire logic                  advance_or_load,
  input  wire logic                  clock_qualifier_n,
  input  wire logic                  burstOrderInterleaved,
  // power and output control
  input  wire logic                  sleep_request,
  input  wire logic                  outputEnableN,
  output logic                       lowPower,
  // data bus, split into byte and parity parts
  input  wire logic [LANES*8-1:0]    dataIn,
  input  wire logic [LANES-1:0]      lane_parity_bit_in,
  output logic      [LANES*8-1:0]    dataOut,
  output logic      [LANES-1:0]      lane_parity_bit_out,
  output logic                       dataOe
);

  localparam int LANE_W = `SRAM_LANE_W;
  localparam int BYTE_W = `SRAM_BYTE_W;
  localparam int WORD_W = LANES * LANE_W;

  // join bytes and parity into stored lanes
  function automatic logic [WORD_W-1:0] packWord(
    input logic [LANES*BYTE_W-1:0] bytes,
    input logic [LANES-1:0]        par
  );
    logic [WORD_W-1:0] w;
    w = '0;
    for (int l = 0; l < LANES; l++) begin
      w[l*LANE_W +: BYTE_W]            = bytes[l*BYTE_W +: BYTE_W];
      w[l*LANE_W + `SRAM_PARITY_POS]   = par[l];
    end
    return w;
  endfunction

  // byte part of a stored word
  function automatic logic [LANES*BYTE_W-1:0] wordBytes(
    input logic [WORD_W-1:0] w
  );
    logic [LANES*BYTE_W-1:0] b;
    b = '0;
    for (int l = 0; l < LANES; l++) begin
      b[l*BYTE_W +: BYTE_W] = w[l*LANE_W +: BYTE_W];
    end
    return b;
  endfunction

  // parity part of a stored word
  function automatic logic [LANES-1:0] wordParity(
    input logic [WORD_W-1:0] w
  );
    logic [LANES-1:0] p;
    p = '0;
    for (int l = 0; l < LANES; l++) begin
      p[l] = w[l*LANE_W + `SRAM_PARITY_POS];
    end
    return p;
  endfunction

  // burst low address bits for a beat, linear or interleaved
  function automatic logic [1:0] burstLow(
    input logic [1:0] base,
    input logic [1:0] beat,
    input logic       interleaved
  );
    logic [1:0] r;
    r = interleaved ? (base ^ beat) : 2'(base + beat);
    return r;
  endfunction

  // overlay the written lanes onto a word read in the same edge
  function automatic logic [WORD_W-1:0] mergeLanes(
    input logic [WORD_W-1:0] oldW,
    input logic [WORD_W-1:0] newW,
    input logic [LANES-1:0]  mask
  );
    logic [WORD_W-1:0] m;
    m = oldW;
    for (int l = 0; l < LANES; l++) begin
      if (mask[l]) begin
        m[l*LANE_W +: LANE_W] = newW[l*LANE_W +: LANE_W];
      end
    end
    return m;
  endfunction

  // registered command and the forwarding record
  cmd_t              cmd_r;
  cmd_t              cmd_nxt;
  logic              fwdHit_r;
  logic              fwdHit_nxt;
  logic [WORD_W-1:0] fwdData_r;
  logic [LANES-1:0]  fwdMask_r;
  logic [WORD_W-1:0] memQ;

  // edge qualification and selection decode
  wire logic edgeOn   = !clock_qualifier_n;                    // [RULE2]
  wire logic selected = !chip_select_a_n && chip_select_b
                        && !chip_select_c_n;                   // [RULE7]
  wire logic loadNew  = !advance_or_load;                      // [RULE13]
  wire logic asleep   = sleep_request;

  // operation for the data phase that the next edge opens
  wire op_t opNew  = !selected ? OP_IDLE
                   : (writeStrobeN ? OP_READ : OP_WRITE);      // [RULE5]
  wire op_t opNext = asleep  ? OP_IDLE                         // [RULE12]
                   : loadNew ? opNew : cmd_r.op;               // [RULE3]

  // burst address stepping on advance
  wire logic [1:0] beatNext = loadNew ? `SRAM_RST_BEAT
                            : 2'(cmd_r.beat + `SRAM_BEAT_STEP); // [RULE13]
  wire logic [1:0] baseNext = loadNew
                            ? {burst_addr_bit1, burst_addr_bit0}
                            : cmd_r.base;
  wire logic [1:0] lowNext  = burstLow(baseNext, beatNext,
                                       burstOrderInterleaved); // [RULE11]
  wire logic [ADDR_W-1:2] upperNext = loadNew ? addrUpper
                                    : cmd_r.addr[ADDR_W-1:2];

  // next command assembled from the pins
  always_comb begin
    cmd_nxt          = cmd_r;
    cmd_nxt.op       = opNext;
    cmd_nxt.addr     = `SRAM_ADDR_W'({upperNext, lowNext});
    cmd_nxt.base     = baseNext;
    cmd_nxt.beat     = beatNext;
    cmd_nxt.laneMask = ~byte_lane_write_sel_n;                 // [RULE5]
  end

  // memory port controls
  wire logic              writeNow  = edgeOn
                                      && (cmd_r.op == OP_WRITE); // [RULE6]
  wire logic [LANES-1:0]  wrLane    = writeNow ? cmd_r.laneMask
                                               : '0;           // [RULE5]
  wire logic              readNow   = edgeOn
                                      && (opNext == OP_READ);  // [RULE10]
  wire logic [WORD_W-1:0] wrWord    = packWord(dataIn,
                                        lane_parity_bit_in);   // [RULE4]

  // a read of the word being written this edge sees the new lanes
  always_comb begin
    fwdHit_nxt = fwdHit_r;
    if (readNow) begin
      fwdHit_nxt = writeNow && (cmd_nxt.addr == cmd_r.addr);   // [RULE3]
    end
  end

  // input registers; a stalled edge holds everything
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cmd_r.op       <= OP_IDLE;
      cmd_r.addr     <= `SRAM_RST_ADDR;
      cmd_r.base     <= `SRAM_RST_BEAT;
      cmd_r.beat     <= `SRAM_RST_BEAT;
      cmd_r.laneMask <= `SRAM_RST_MASK;
    end else if (edgeOn) begin                                 // [RULE2]
      cmd_r <= cmd_nxt;                                        // [RULE1]
    end
  end

  // forwarding record for read-after-write on one address
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fwdHit_r  <= 1'b0;
      fwdData_r <= '0;
      fwdMask_r <= '0;
    end else if (readNow) begin
      fwdHit_r  <= fwdHit_nxt;
      fwdData_r <= wrWord;
      fwdMask_r <= wrLane;
    end
  end

  // storage array with registered read data
  sram_word_store #(
    .LANES  (LANES),
    .LANE_W (LANE_W),
    .DEPTH  (DEPTH),
    .ADDR_W (ADDR_W)
  ) u_store (
    .clock  (clock),
    .rst_n  (rst_n),
    .wrLane (wrLane),
    .wrAddr (cmd_r.addr[ADDR_W-1:0]),
    .wrData (wrWord),
    .rdEn   (readNow),
    .rdAddr (cmd_nxt.addr[ADDR_W-1:0]),
    .rdData (memQ)
  );

  // read data valid through the cycle opened by the address edge
  wire logic [WORD_W-1:0] readWord = fwdHit_r
                          ? mergeLanes(memQ, fwdData_r, fwdMask_r)
                          : memQ;                              // [RULE10]

  // data and parity outputs
  assign dataOut             = wordBytes(readWord);
  assign lane_parity_bit_out = wordParity(readWord);           // [RULE4]

  // drivers on only in a read data phase with output enable low
  assign dataOe = (cmd_r.op == OP_READ)                        // [RULE9]
                  && !outputEnableN;                           // [RULE8]

  // low power while asleep or with no operation in progress
  assign lowPower = asleep || (cmd_r.op == OP_IDLE);           // [RULE12]

endmodule // flow_through_sync_burst_sram

`default_nettype wire

//--- src/burst_sram_consts.svh
// constants for the flow-through burst memory: widths, field positions,
// reset values; included by the package and by the design modules
`ifndef BURST_SRAM_CONSTS_SVH
`define BURST_SRAM_CONSTS_SVH

// organisation: 256K words of four 9-bit lanes
`define SRAM_ADDR_W      18
`define SRAM_DEPTH       262144
`define SRAM_LANES       4
`define SRAM_BYTE_W      8
`define SRAM_LANE_W      9

// burst counter covers the two lowest address bits, four beats
`define SRAM_BURST_W     2
`define SRAM_BEAT_STEP   2'h1

// position of the parity bit inside one stored lane
`define SRAM_PARITY_POS  8

// reset values of the registered command
`define SRAM_RST_ADDR    18'h00000
`define SRAM_RST_BEAT    2'h0
`define SRAM_RST_MASK    4'h0

`endif

//--- src/burst_sram_pkg.sv
// types shared by the burst memory modules
// assumes burst_sram_consts.svh is on the include path
`include "burst_sram_consts.svh"

package burst_sram_pkg;

  // operation owning the current data phase
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_t;

  // command held in the input registers
  typedef struct packed {
    op_t                          op;
    logic [`SRAM_ADDR_W-1:0]      addr;
    logic [`SRAM_BURST_W-1:0]     base;
    logic [`SRAM_BURST_W-1:0]     beat;
    logic [`SRAM_LANES-1:0]       laneMask;
  } cmd_t;

endpackage

//--- src/sram_word_store.sv
// word array with per-lane write enables and a registered read port
// assumes one clock; write and read of one address in one edge give old data
`timescale 1ns/1ps
`default_nettype none
`include "burst_sram_consts.svh"

module sram_word_store #(
  parameter int LANES  = `SRAM_LANES,
  parameter int LANE_W = `SRAM_LANE_W,
  parameter int DEPTH  = `SRAM_DEPTH,
  parameter int ADDR_W = `SRAM_ADDR_W
) (
  // clock and reset
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  // write port
  input  wire logic [LANES-1:0]        wrLane,
  input  wire logic [ADDR_W-1:0]       wrAddr,
  input  wire logic [LANES*LANE_W-1:0] wrData,
  // read port
  input  wire logic                    rdEn,
  input  wire logic [ADDR_W-1:0]       rdAddr,
  output logic      [LANES*LANE_W-1:0] rdData
);

  logic [LANES*LANE_W-1:0] mem [DEPTH];

  // one write process for all lanes, so the array has a single writer
  always_ff @(posedge clock) begin
    for (int l = 0; l < LANES; l++) begin
      if (wrLane[l]) begin
        mem[wrAddr][l*LANE_W +: LANE_W] <= wrData[l*LANE_W +: LANE_W];
      end
    end
  end

  // registered read data
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdData <= '0;
    end else if (rdEn) begin
      rdData <= mem[rdAddr];
    end
  end

endmodule // sram_word_store

`default_nettype wire

//--- testbench/burst_sram_chk.sv
// port timing checks for the flow-through burst memory
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module burst_sram_chk #(
  parameter int LANES = 4
) (
  // clock and reset
  input wire logic             clock,
  input wire logic             rst_n,
  // control
  input wire logic             chip_select_a_n,
  input wire logic             chip_select_b,
  input wire logic             chip_select_c_n,
  input wire logic             writeStrobeN,
  input wire logic             advance_or_load,
  input wire logic             clock_qualifier_n,
  input wire logic             sleep_request,
  input wire logic             outputEnableN,
  // outputs
  input wire logic             lowPower,
  input wire logic [LANES*8-1:0] dataOut,
  input wire logic             dataOe
);
  // enabled load edge, selected and awake
  wire ld  = !clock_qualifier_n && !advance_or_load;
  wire sel = !chip_select_a_n && chip_select_b && !chip_select_c_n;
  wire go  = ld && sel && !sleep_request;
  wire adv = !clock_qualifier_n && advance_or_load;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_RD: assert property (go && writeStrobeN |=> dataOe || outputEnableN)
    else $error("read phase without drivers");
  AST_WR: assert property (go && !writeStrobeN |=> !dataOe)
    else $error("drivers on in write phase");
  AST_DSEL: assert property (ld && !sel |=> !dataOe)
    else $error("drivers on while deselected");
  AST_SLP: assert property (ld && sleep_request |=> !dataOe && lowPower)
    else $error("sleep load not idle");
  AST_ZZ: assert property (sleep_request |-> lowPower)
    else $error("sleep without low power");
  AST_OE: assert property (outputEnableN |-> !dataOe)
    else $error("drivers on with output enable off");
  AST_HOLD: assert property (clock_qualifier_n |=> $stable(dataOut))
    else $error("data moved on an ignored edge");
  AST_HOLDOE: assert property ((clock_qualifier_n && !outputEnableN)
    ##1 !outputEnableN |-> $stable(dataOe))
    else $error("drive moved on an ignored edge");
  AST_ADV: assert property (adv && dataOe && !sleep_request
    |=> dataOe || outputEnableN)
    else $error("read burst beat lost");
  AST_ADVI: assert property (adv && !dataOe && !outputEnableN
    |=> !dataOe)
    else $error("advance left idle or write phase");

  // main scenarios reached
  cover property (go && writeStrobeN);
  cover property (go && !writeStrobeN);
  cover property (clock_qualifier_n && dataOe);
endmodule // burst_sram_chk

bind flow_through_sync_burst_sram burst_sram_chk #(.LANES(LANES))
  burst_sram_chk_i (.clock, .rst_n, .chip_select_a_n, .chip_select_b,
  .chip_select_c_n, .writeStrobeN, .advance_or_load, .clock_qualifier_n,
  .sleep_request, .outputEnableN, .lowPower, .dataOut, .dataOe);
`default_nettype wire

//--- testbench/sram_ctrl_model.sv
// controller write-data side: drives the bus only in write data phases
// assumes the bench marks which cycles are write data phases
`timescale 1ns/1ps
`default_nettype none
module sram_ctrl_model (
  // clock
  input wire logic         clock,
  // request from the bench
  input wire logic         drive,
  input wire logic [35:0]  word,
  // bus toward the memory
  output logic     [31:0]  dataIn,
  output logic     [3:0]   parIn
);
  logic [35:0] last_r = 36'h0;
  // released bus shows the inverse of the last value
  assign {parIn, dataIn} = drive ? word : ~last_r;
  // remember the bus each edge
  always_ff @(posedge clock) last_r <= {parIn, dataIn};
endmodule // sram_ctrl_model
`default_nettype wire

//--- testbench/flow_through_sync_burst_sram_bench.sv
// self-checking bench for the flow-through burst memory
// assumes a small depth; far side modelled by sram_ctrl_model
`timescale 1ns/1ps
`default_nettype none
module flow_through_sync_burst_sram_bench;
  logic        clock, rst_n, burst_addr_bit0, burst_addr_bit1, drive;
  logic        chip_select_a_n, chip_select_b, chip_select_c_n;
  logic        writeStrobeN, advance_or_load, clock_qualifier_n;
  logic        burstOrderInterleaved, sleep_request, outputEnableN;
  logic        lowPower, dataOe, pw, slp, ord;
  logic [7:2]  addrUpper;
  logic [2:0]  cs;
  logic [3:0]  byte_lane_write_sel_n, parIn, parOut;
  logic [31:0] dataIn, dataOut;
  logic [35:0] word, pWord, pExp;
  logic [35:0] mem [256];
  int          mismatches, n_compared, cycles, pk;

  flow_through_sync_burst_sram #(.ADDR_W(8), .DEPTH(256), .LANES(4))
    flow_through_sync_burst_sram_i (.clock, .rst_n, .addrUpper,
    .burst_addr_bit0, .burst_addr_bit1, .chip_select_a_n, .chip_select_b,
    .chip_select_c_n, .writeStrobeN, .byte_lane_write_sel_n,
    .advance_or_load, .clock_qualifier_n, .burstOrderInterleaved,
    .sleep_request, .outputEnableN, .lowPower, .dataIn,
    .lane_parity_bit_in(parIn), .dataOut, .lane_parity_bit_out(parOut),
    .dataOe);
  sram_ctrl_model sram_ctrl_model_i (.clock, .drive, .word, .dataIn, .parIn);

  // 50 MHz clock
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // hang guard
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 500) begin
      mismatches++;
      results();
    end
  end

  // verdict and end of run
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // compare and count
  task automatic chk(string what, logic [36:0] exp, logic [36:0] got);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", what, exp, got);
    end
  endtask

  // test word built from its address
  function automatic logic [35:0] f(logic [7:0] a);
    return {a[3:0], a, ~a, a, 8'h5a};
  endfunction

  // judge the data phase of the last command
  task automatic look();
    #1;
    if (pk == 1) chk("read", {1'b1, pExp}, {dataOe, parOut, dataOut});
    else chk("dataOe", 37'h0, {36'h0, dataOe});
    chk("lowPower", {36'h0, pk == 2 || slp}, {36'h0, lowPower});
  endtask

  // one enabled edge; k: 0 write, 1 read, 2 idle
  task automatic op(logic ld, logic [7:0] a, logic [3:0] ln,
                    logic [35:0] w, int k);
    @(posedge clock);
    clock_qualifier_n <= 1'b0;
    advance_or_load <= !ld;
    writeStrobeN <= k != 0;
    {addrUpper, burst_addr_bit1, burst_addr_bit0} <= a;
    byte_lane_write_sel_n <= ln;
    {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
    {sleep_request, burstOrderInterleaved} <= {slp, ord};
    {drive, word} <= {pw, pWord};
    look();
    pw = k == 0;
    pWord = w;
    for (int l = 0; l < 4; l++) if (pw && !ln[l]) begin
      mem[a][8*l +: 8] = w[8*l +: 8];
      mem[a][32+l] = w[32+l];
    end
    pk = k;
    pExp = mem[a];
  endtask

  // ignored edges; outputs must hold
  task automatic stall(int n);
    repeat (n) begin
      @(posedge clock);
      clock_qualifier_n <= 1'b1;
      {drive, word} <= {pw, pWord};
      look();
    end
  endtask

  // reset leaves the memory idle
  task automatic t_reset();
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    #1;
    chk("lowPower", 37'h1, {36'h0, lowPower});
  endtask

  // back-to-back writes and reads, partial lanes
  task automatic t_b2b();
    cs = 3'b010;
    op(1, 8'h01, 4'h0, f(8'h01), 0);
    op(1, 8'h01, 4'h0, 36'h0, 1);
    op(1, 8'h02, 4'h0, f(8'h02), 0);
    op(1, 8'h01, 4'ha, f(8'h77), 0);
    op(1, 8'h01, 4'h0, 36'h0, 1);
    op(1, 8'h02, 4'h0, 36'h0, 1);
  endtask

  // write burst, then read bursts in both orders from base 1
  task automatic t_burst();
    for (int i = 0; i < 4; i++) op(1, 8'h10 + 8'(i), 4'h0, f(8'h10 + 8'(i)), 0);
    op(1, 8'h20, 4'h0, f(8'h20), 0);
    op(0, 8'h21, 4'h0, f(8'h21), 0);
    op(1, 8'h21, 4'h0, 36'h0, 1);
    for (int o = 0; o < 2; o++) begin
      ord = o[0];
      for (int i = 0; i < 4; i++)
        op(i == 0, {6'h04, 2'(o ? 1 ^ i : 1 + i)}, 4'h0, 36'h0, 1);
      op(1, 8'h13, 4'h0, 36'h0, 1);
    end
  endtask

  // stalls in a read phase and in a write phase
  task automatic t_stall();
    op(1, 8'h11, 4'h0, 36'h0, 1);
    stall(3);
    op(1, 8'h30, 4'h0, f(8'h30), 0);
    stall(2);
    op(1, 8'h30, 4'h0, 36'h0, 1);
  endtask

  // each select inactive, then sleep
  task automatic t_select();
    for (int i = 0; i < 3; i++) begin
      cs = 3'b010 ^ (3'b100 >> i);
      op(1, 8'h10, 4'h0, 36'h0, 2);
      op(0, 8'h11, 4'h0, 36'h0, 2);
    end
    cs = 3'b010;
    slp = 1'b1;
    op(1, 8'h10, 4'h0, 36'h0, 2);
    op(1, 8'h10, 4'h0, 36'h0, 2);
    chk("lowPower", 37'h1, {36'h0, lowPower});
    slp = 1'b0;
  endtask

  // output enable acts without a clock edge
  task automatic t_oe();
    op(1, 8'h12, 4'h0, 36'h0, 1);
    @(posedge clock);
    clock_qualifier_n <= 1'b1;
    outputEnableN <= 1'b1;
    #1;
    chk("dataOe", 37'h0, {36'h0, dataOe});
    outputEnableN <= 1'b0;
    stall(1);
  endtask

  // main sequence
  initial begin
    {rst_n, clock_qualifier_n, advance_or_load, addrUpper} = '0;
    {burst_addr_bit0, burst_addr_bit1, chip_select_b} = '0;
    {chip_select_a_n, chip_select_c_n, writeStrobeN} = 3'h7;
    {byte_lane_write_sel_n, burstOrderInterleaved, sleep_request} = 6'h3c;
    {outputEnableN, drive, word, pw, pWord, slp, ord} = '0;
    {mismatches, n_compared, cycles, pk, cs} = '0;
    cs = 3'b110;
    pk = 2;
    t_reset();
    t_b2b();
    t_burst();
    t_stall();
    t_select();
    t_oe();
    results();
  end
endmodule // flow_through_sync_burst_sram_bench
`default_nettype wire
